// [obt_bit.sv]
// One transceiver bit slice: source muxes for both directions.
`timescale 1ns/1ps
`default_nettype none

module obt_bit #(
    parameter bit INVERT = 1'b0
) (
    // Live pin levels and stored bits.
    input  wire logic a_live_i,
    input  wire logic b_live_i,
    input  wire logic a_stored_i,
    input  wire logic b_stored_i,
    // Source selects.
    input  wire logic a_to_b_sel_i,
    input  wire logic b_to_a_sel_i,
    // Values offered to each port.
    output logic      to_b_o,
    output logic      to_a_o
);

    wire logic ab_src;
    wire logic ba_src;

    assign ab_src = a_to_b_sel_i ? a_stored_i : a_live_i;
    assign ba_src = b_to_a_sel_i ? b_stored_i : b_live_i;
    assign to_b_o = ab_src ^ INVERT;
    assign to_a_o = ba_src ^ INVERT;

endmodule

`default_nettype wire

// [obt_bus_partner.sv]
// Far-side model of one bus together with the resolved wire level.
`timescale 1ns/1ps
`default_nettype none
module obt_bus_partner (
    // Far-side drive and device side.
    input  wire logic       clk_i,
    input  wire logic       drive_i,
    input  wire logic [7:0] val_i,
    input  wire logic [7:0] dev_oe_i,
    input  wire logic [7:0] dev_val_i,
    output logic      [7:0] bus_o
);
    logic [7:0] last_reg;
    // The far side lets go of every line the device drives; a floating line keeps toggling.
    assign bus_o = (dev_oe_i & dev_val_i) | (~dev_oe_i & (drive_i ? val_i : ~last_reg));
    always_ff @(posedge clk_i) last_reg <= bus_o;
endmodule
`default_nettype wire

// [obt_checker.sv]
// Port assertions for the transceiver.
`timescale 1ns/1ps
`default_nettype none
module obt_checker (
    // Watched ports.
    input wire logic               CLK_I,
    input wire logic               RST_N_I,
    input wire obt_pkg::obt_ctrl_t CTRL_I,
    input wire logic [7:0]         A_I,
    input wire logic [7:0]         A_O,
    input wire logic [7:0]         A_OE_O,
    input wire logic [7:0]         B_I,
    input wire logic [7:0]         B_O,
    input wire logic [7:0]         B_OE_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RST_N_I);
    wire logic en_ab = CTRL_I.a_to_b_output_enable;
    wire logic en_ba_n = CTRL_I.b_to_a_output_enable_n;
    wire logic sel_ab = CTRL_I.a_to_b_source_select;
    wire logic sel_ba = CTRL_I.b_to_a_source_select;
    sequence s_cap_a; !CTRL_I.a_capture_clock ##1 CTRL_I.a_capture_clock; endsequence
    sequence s_cap_b; !CTRL_I.b_capture_clock ##1 CTRL_I.b_capture_clock; endsequence
    property p_b_drive; en_ab |=> B_OE_O == 8'hFF; endproperty
    property p_isolate; !en_ab && en_ba_n |=> (A_OE_O | B_OE_O) == 8'h00; endproperty
    property p_a_drive; !en_ba_n |=> A_OE_O == 8'hFF; endproperty
    property p_live_ab; en_ab && !sel_ab |=> B_O == $past(A_I); endproperty
    property p_live_ba; !en_ba_n && !sel_ba |=> A_O == $past(B_I); endproperty
    property p_kept_ab; s_cap_a ##1 (en_ab && sel_ab) |=> B_O == $past(A_I, 2); endproperty
    property p_kept_ba; s_cap_b ##1 (!en_ba_n && sel_ba) |=> A_O == $past(B_I, 2); endproperty
    property p_both; en_ab && !en_ba_n |=> (A_OE_O & B_OE_O) == 8'hFF; endproperty
    a_b_drive: assert property (p_b_drive) else $error("B port not driven");
    a_isolate: assert property (p_isolate) else $error("port driven in isolation");
    a_a_drive: assert property (p_a_drive) else $error("A port not driven");
    a_live_ab: assert property (p_live_ab) else $error("live A to B wrong");
    a_live_ba: assert property (p_live_ba) else $error("live B to A wrong");
    a_kept_ab: assert property (p_kept_ab) else $error("stored A to B wrong");
    a_kept_ba: assert property (p_kept_ba) else $error("stored B to A wrong");
    a_both: assert property (p_both) else $error("both ports not driven");
endmodule
bind obt_top obt_checker u_chk (.CLK_I(CLK_I), .RST_N_I(RST_N_I), .CTRL_I(CTRL_I),
    .A_I(A_I), .A_O(A_O), .A_OE_O(A_OE_O), .B_I(B_I), .B_O(B_O), .B_OE_O(B_OE_O));
`default_nettype wire

// [obt_pkg.sv]
// Package of constants and types for the octal registered bus transceiver.
//
// Function
// - Each direction forwards live bus data when its select is low and stored data when high.
// - The A register loads on a rising A capture clock, the B register on a rising B capture clock.
// - Capture is never gated by enables, so every capture edge stores the bus level: the device's own drive where it drives, else the pin.
// - Live selects with both enables active make each output drive back onto its own input.
// - In that mutual-drive state the A and B buses swap their values on every clock edge.
// - A-to-B enable low, B-to-A enable low and B-to-A select low drive live B data onto A.
// - Same enables with B-to-A select high drive the stored B register onto A.
// - Both enables high with A-to-B select low drive live A data onto B.
// - Both enables high with A-to-B select high drive the stored A register onto B.
// - A-to-B enable high, B-to-A enable low and both selects high drive both stored words.
// - Both enables high load A-originated data into both registers on both capture edges.
// - Both enables low load B-originated data into both registers on both capture edges.
// - The A-to-B enable (high) drives B, the B-to-A enable (low) drives A; else isolation.
// - Data comes from the opposite bus or the capture register, muxed onto three-state outputs.
`default_nettype none

package obt_pkg;

    localparam int unsigned DATA_W = 8;

    // Reset value of both capture registers and of all pin outputs.
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    // Reset value of the sampled capture clocks, taken as idle low.
    localparam logic CLK_RST = 1'b0;

    // Control pins of the transceiver.
    typedef struct packed {
        logic a_to_b_output_enable;
        logic b_to_a_output_enable_n;
        logic a_capture_clock;
        logic b_capture_clock;
        logic a_to_b_source_select;
        logic b_to_a_source_select;
    } obt_ctrl_t;

    // One three-state bus port driver, split into output data and enable.
    typedef struct packed {
        logic [DATA_W-1:0] dout;
        logic [DATA_W-1:0] oe;
    } obt_drv_t;

endpackage

`default_nettype wire

// [obt_top.sv]
// Octal registered bus transceiver, synchronous model of the pin behaviour.
`timescale 1ns/1ps
`default_nettype none

module obt_top #(
    parameter bit INVERT = 1'b0
) (
    // Clock and reset.
    input  wire logic                       CLK_I,
    input  wire logic                       RST_N_I,
    // Control pins.
    input  wire obt_pkg::obt_ctrl_t         CTRL_I,
    // A bus.
    input  wire logic [obt_pkg::DATA_W-1:0] A_I,
    output logic      [obt_pkg::DATA_W-1:0] A_O,
    output logic      [obt_pkg::DATA_W-1:0] A_OE_O,
    // B bus.
    input  wire logic [obt_pkg::DATA_W-1:0] B_I,
    output logic      [obt_pkg::DATA_W-1:0] B_O,
    output logic      [obt_pkg::DATA_W-1:0] B_OE_O
);

    ////////////////////////////////////////////////////////////////////////////
    // Capture clock edge detection and registers.

    logic                       a_clk_reg;
    logic                       b_clk_reg;
    logic [obt_pkg::DATA_W-1:0] a_store_reg;
    logic [obt_pkg::DATA_W-1:0] b_store_reg;
    logic [obt_pkg::DATA_W-1:0] a_store_next;
    logic [obt_pkg::DATA_W-1:0] b_store_next;
    wire logic                  a_rise;
    wire logic                  b_rise;
    wire logic                  drive_b;
    wire logic                  drive_a;
    wire logic [obt_pkg::DATA_W-1:0] to_b;
    wire logic [obt_pkg::DATA_W-1:0] to_a;
    wire logic [obt_pkg::DATA_W-1:0] a_level;
    wire logic [obt_pkg::DATA_W-1:0] b_level;

    assign a_rise = CTRL_I.a_capture_clock & ~a_clk_reg;
    assign b_rise = CTRL_I.b_capture_clock & ~b_clk_reg;

    assign drive_b = CTRL_I.a_to_b_output_enable;
    assign drive_a = ~CTRL_I.b_to_a_output_enable_n;

    // The level on a bus line is what the device really drives on it, else the pin.
    // Only the registered enable counts: a new enable reaches the pins one edge later.
    // When both directions drive live data, each output takes the other bus's level and the
    // two buses swap values on every edge without touching the capture registers.
    assign a_level = (A_OE_O & A_O) | (~A_OE_O & A_I);
    assign b_level = (B_OE_O & B_O) | (~B_OE_O & B_I);

    // Capture never depends on enables or selects; it stores the bus level.
    assign a_store_next = a_rise ? a_level : a_store_reg;
    assign b_store_next = b_rise ? b_level : b_store_reg;

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            a_clk_reg   <= obt_pkg::CLK_RST;
            b_clk_reg   <= obt_pkg::CLK_RST;
            a_store_reg <= obt_pkg::DATA_RST;
            b_store_reg <= obt_pkg::DATA_RST;
        end else begin
            a_clk_reg   <= CTRL_I.a_capture_clock;
            b_clk_reg   <= CTRL_I.b_capture_clock;
            a_store_reg <= a_store_next;
            b_store_reg <= b_store_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-bit source selection.

    genvar gi;
    generate
        for (gi = 0; gi < obt_pkg::DATA_W; gi++) begin : g_bit
            obt_bit #(
                .INVERT       (INVERT)
            ) u_bit (
                .a_live_i     (a_level[gi]),
                .b_live_i     (b_level[gi]),
                .a_stored_i   (a_store_reg[gi]),
                .b_stored_i   (b_store_reg[gi]),
                .a_to_b_sel_i (CTRL_I.a_to_b_source_select),
                .b_to_a_sel_i (CTRL_I.b_to_a_source_select),
                .to_b_o       (to_b[gi]),
                .to_a_o       (to_a[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Registered pin drivers.

    always_ff @(posedge CLK_I or negedge RST_N_I) begin
        if (!RST_N_I) begin
            A_O    <= obt_pkg::DATA_RST;
            B_O    <= obt_pkg::DATA_RST;
            A_OE_O <= obt_pkg::DATA_RST;
            B_OE_O <= obt_pkg::DATA_RST;
        end else begin
            A_O    <= to_a;
            B_O    <= to_b;
            A_OE_O <= {obt_pkg::DATA_W{drive_a}};
            B_OE_O <= {obt_pkg::DATA_W{drive_b}};
        end
    end

endmodule

`default_nettype wire

// [obt_top_bench.sv]
// Self-checking random bench for the transceiver.
`timescale 1ns/1ps
`default_nettype none
module obt_top_bench;
    logic clk = 1'b0, rst_n = 1'b0, pa_en = 1'b1, pb_en = 1'b1;
    obt_pkg::obt_ctrl_t ctrl = '0;
    logic [7:0] pa_val = 8'h00, pb_val = 8'h00, a_in, a_out, a_oe, b_in, b_out, b_oe;
    int fail_count = 0, checks_done = 0, st_a, st_b, pca, pcb, e_ao, e_aoe, e_bo, e_boe;
    always #10 clk = ~clk;
    obt_top u_dut (.CLK_I(clk), .RST_N_I(rst_n), .CTRL_I(ctrl), .A_I(a_in), .A_O(a_out),
        .A_OE_O(a_oe), .B_I(b_in), .B_O(b_out), .B_OE_O(b_oe));
    obt_bus_partner u_pa (.clk_i(clk), .drive_i(pa_en), .val_i(pa_val), .dev_oe_i(a_oe),
        .dev_val_i(a_out), .bus_o(a_in));
    obt_bus_partner u_pb (.clk_i(clk), .drive_i(pb_en), .val_i(pb_val), .dev_oe_i(b_oe),
        .dev_val_i(b_out), .bus_o(b_in));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // Reference model: stores load on a rising capture level, outputs lag one edge.
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            {st_a, st_b, pca, pcb, e_ao, e_aoe, e_bo, e_boe} = '0;
        end else begin
            e_bo = ctrl.a_to_b_source_select ? st_a : a_in;
            e_ao = ctrl.b_to_a_source_select ? st_b : b_in;
            e_boe = ctrl.a_to_b_output_enable ? 8'hFF : 8'h00;
            e_aoe = ctrl.b_to_a_output_enable_n ? 8'h00 : 8'hFF;
            if (ctrl.a_capture_clock && !pca) st_a = a_in;
            if (ctrl.b_capture_clock && !pcb) st_b = b_in;
            pca = ctrl.a_capture_clock;
            pcb = ctrl.b_capture_clock;
        end
    end
    always @(negedge clk) begin
        if (rst_n) begin
            check(a_oe, e_aoe[7:0]);
            check(b_oe, e_boe[7:0]);
            if (e_aoe != 0) check(a_out, e_ao[7:0]);
            if (e_boe != 0) check(b_out, e_bo[7:0]);
        end
    end
    initial begin
        void'($urandom(32'hCFD1));
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3000) begin
            @(posedge clk);
            ctrl <= obt_pkg::obt_ctrl_t'(6'($urandom));
            pa_val <= 8'($urandom);
            pb_val <= 8'($urandom);
            pa_en <= ($urandom % 4) != 0;
            pb_en <= ($urandom % 4) != 0;
        end
        give_verdict();
    end
    initial begin
        #100000;
        fail_count++;
        give_verdict();
    end
endmodule
`default_nettype wire
